// *** rtl/dma_channel_status.sv ***
/*
 * Status flags, interrupt request and trigger selection of one DMA channel.
 * Assumes the transfer engine supplies enable, busy, counter, completion and
 * access strobes on the same clock, and peripheral lines on src_irq.
 */
// Functional notes
// - Disabled: done flag tells last session outcome.
// - Enabled: done clear during session, set after.
// - Set halfway flag at half programmed count.
// - Trigger while busy sets overrun flag.
// - Halfway enabled: interrupt at half and completion.
// - Halfway disabled: interrupt only at completion.
// - Software flag writes raise no interrupt.
// - Limits checked after the access happens.
// - Bits two and one read zero.
// - Codes 00,08,0B,0D select external irqs 0-3.
// - 27h group done; 28h-3Fh analog inputs.
// - Codes 40h-43h select oversample filters 1-4.
// - 44h,45h,60h,61h select logic cells 1-4.
// - Code 18h selects checksum generator.
// - Code 06h selects memory ECC single-bit event.
// - 09h,13h,64h select two-wire target events.
`timescale 1ns/1ps
`include "dma_chan_params.svh"

module dma_channel_status
    import dma_chan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [127:0] src_irq,
    input wire logic channel_enable,
    input wire logic busy,
    input wire logic xfer_done,
    input wire logic cnt_dec,
    input wire logic [15:0] channel_transfer_counter,
    input wire logic [15:0] count_init,
    input wire access_t access,
    input wire logic [15:0] upper_address_limit,
    input wire logic [15:0] lower_address_limit,
    input wire logic buf_write_pending,
    output logic trigger_pulse,
    output logic channel_irq
);

    flags_t flags_reg;
    flags_t flags_next;
    flags_t flags_set;
    trig_code_t code_reg;
    trig_code_t code_next;
    logic half_en_reg;
    logic half_en_next;
    logic en_prev_reg;
    logic en_prev_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic trig_reg;
    logic trig_next;
    logic irq_reg;
    logic irq_next;
    logic [15:0] status_word;
    logic sel_wr;
    logic sel_rd;
    logic trig_evt;
    logic half_evt;
    logic session_start;

    assign sel_wr = reg_wr && (reg_addr == `CHAN_INT_STATUS_OFS);
    assign sel_rd = reg_rd && (reg_addr == `CHAN_INT_STATUS_OFS);

    trigger_select u_trigger_select (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .code(code_reg),
        .src_irq(src_irq),
        .trig_evt(trig_evt)
    );

    // The code is the index of the source line; the known lines are wired as:
    // 00h/08h/0Bh/0Dh external irqs, 27h group, 28h-3Fh analog inputs 0-23
    // 40h-43h filters 1-4, 44h/45h/60h/61h logic cells 1-4
    // 18h checksum, 06h ECC, 09h/13h/64h two-wire targets.
    // Reserved codes stay inert even if software ignores the usage limit.

    assign half_evt = cnt_dec && (channel_transfer_counter == {1'b0, count_init[15:1]});
    assign session_start = channel_enable && !en_prev_reg;

    always_comb begin
        flags_set = '0;
        flags_set.done = xfer_done;
        flags_set.half = half_evt;
        flags_set.ovr = trig_evt && busy;
        // Comparison uses the address of an access already performed.
        flags_set.upper = access.valid && (access.addr > upper_address_limit);
        flags_set.lower = access.valid && (access.addr < lower_address_limit);
    end

    always_comb begin
        flags_next = flags_reg;
        code_next = code_reg;
        half_en_next = half_en_reg;
        en_prev_next = en_prev_reg;
        if (clk_en) begin
            en_prev_next = channel_enable;
            // A new session clears the outcome; while disabled it is held.
            if (session_start) begin
                flags_next.done = 1'b0;
            end
            if (sel_wr) begin
                code_next = reg_wdata[`ST_CODE_MSB:`ST_CODE_LSB];
                half_en_next = reg_wdata[`ST_HALF_EN_BIT];
                flags_next.upper = reg_wdata[`ST_UPPER_BIT];
                flags_next.lower = reg_wdata[`ST_LOWER_BIT];
                flags_next.done = reg_wdata[`ST_DONE_BIT];
                flags_next.half = reg_wdata[`ST_HALF_BIT];
                flags_next.ovr = reg_wdata[`ST_OVR_BIT];
            end
            // Hardware events win over a same-cycle clear.
            flags_next = flags_next | flags_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags_reg <= `FLAGS_RESET;
            code_reg <= `CODE_RESET;
            half_en_reg <= 1'b0;
            en_prev_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            code_reg <= code_next;
            half_en_reg <= half_en_next;
            en_prev_reg <= en_prev_next;
        end
    end

    // Interrupts come only from hardware events, never from flag writes.
    always_comb begin
        irq_next = irq_reg;
        trig_next = trig_reg;
        if (clk_en) begin
            irq_next = xfer_done || (half_evt && half_en_reg);
            trig_next = trig_evt && channel_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            trig_reg <= trig_next;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[`ST_BUF_PEND_BIT] = buf_write_pending;
        status_word[`ST_CODE_MSB:`ST_CODE_LSB] = code_reg;
        status_word[`ST_UPPER_BIT] = flags_reg.upper;
        status_word[`ST_LOWER_BIT] = flags_reg.lower;
        status_word[`ST_DONE_BIT] = flags_reg.done;
        status_word[`ST_HALF_BIT] = flags_reg.half;
        status_word[`ST_OVR_BIT] = flags_reg.ovr;
        status_word[`ST_HALF_EN_BIT] = half_en_reg;
        // Bits 2 and 1 keep their zero from the default above.
    end

    // Read data stand until the next enabled cycle; an enabled cycle without a read loads zero.
    always_comb begin
        rdata_next = rdata_reg;
        if (clk_en) begin
            rdata_next = sel_rd ? status_word : `RDATA_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_reg <= `RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign trigger_pulse = trig_reg;
    assign channel_irq = irq_reg;

    done_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !channel_enable && flags_reg.done && !sel_wr |=> flags_reg.done)
        else $error("done flag lost while channel disabled");

    done_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && xfer_done |=> flags_reg.done)
        else $error("completion did not set done flag");

    half_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cnt_dec && channel_transfer_counter == {1'b0, count_init[15:1]}
        |=> flags_reg.half)
        else $error("halfway flag not set at half count");

    overrun_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && trig_evt && busy |=> flags_reg.ovr)
        else $error("overrun flag not set");

    half_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && half_evt && half_en_reg |=> channel_irq ##1 (!channel_irq || $past(xfer_done)))
        else $error("halfway interrupt missing");

    no_half_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && half_evt && !half_en_reg && !xfer_done |=> !channel_irq)
        else $error("halfway interrupt while disabled");

    sw_no_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && sel_wr && !xfer_done && !half_evt |=> !channel_irq)
        else $error("flag write raised interrupt");

    limit_after_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && access.valid && access.addr > upper_address_limit |=> flags_reg.upper)
        else $error("upper limit flag not set after access");

    unimpl_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && sel_rd |=> reg_rdata[2:1] == 2'b00 && reg_rdata[0] == $past(half_en_reg))
        else $error("unimplemented bits not zero");

    ovr_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
        flags_reg.ovr && !(clk_en && sel_wr) |=> flags_reg.ovr)
        else $error("overrun flag cleared without write");

    trig_one_a: assert property (@(posedge clk) disable iff (!rst_b)
        trigger_pulse |=> !trigger_pulse)
        else $error("trigger longer than one cycle");

    // Completion must interrupt whatever the halfway enable says.
    done_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && xfer_done |=> channel_irq)
        else $error("completion gave no interrupt");

    irq_source_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !xfer_done && !(half_evt && half_en_reg) |=> !channel_irq)
        else $error("interrupt without a hardware event");

    done_new_session_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && session_start && !xfer_done && !sel_wr |=> !flags_reg.done)
        else $error("done flag not cleared at session start");

    lower_after_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && access.valid && access.addr < lower_address_limit |=> flags_reg.lower)
        else $error("lower limit flag not set after access");

    half_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
        flags_reg.half && !(clk_en && sel_wr) |=> flags_reg.half)
        else $error("halfway flag cleared without write");

    code_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && sel_wr |=> code_reg == $past(reg_wdata[`ST_CODE_MSB:`ST_CODE_LSB]))
        else $error("trigger code not stored");

    trig_select_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && channel_enable && trig_evt |=> trigger_pulse)
        else $error("selected source gave no trigger");

    trig_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !channel_enable |=> !trigger_pulse)
        else $error("trigger while channel disabled");

    // Reserved codes 1Ah and 6Eh upward are checked here too, so a decoder slip cannot arm them.
    rsv_inert_a: assert property (@(posedge clk) disable iff (!rst_b)
        code_reg == `TRIG_RSV_A || code_reg >= `TRIG_RSV_G_FIRST |-> !trig_evt)
        else $error("reserved code produced a trigger");

    rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !sel_rd |=> reg_rdata == `RDATA_RESET)
        else $error("read data outside a read cycle");

    // The enable input freezes everything but reset, outputs included.
    freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !clk_en |=> $stable(flags_reg) && $stable(code_reg) && $stable(channel_irq))
        else $error("state moved while clock enable low");

    half_cycle_c: cover property (@(posedge clk) disable iff (!rst_b)
        half_evt && half_en_reg ##[1:200] xfer_done);
    overrun_c: cover property (@(posedge clk) disable iff (!rst_b) trig_evt && busy);
    status_read_c: cover property (@(posedge clk) disable iff (!rst_b)
        sel_rd && flags_reg.done);
    session_clear_c: cover property (@(posedge clk) disable iff (!rst_b)
        session_start && flags_reg.done);
    lower_limit_c: cover property (@(posedge clk) disable iff (!rst_b)
        access.valid && access.addr < lower_address_limit);

endmodule : dma_channel_status

// *** rtl/dma_chan_params.svh ***
/*
 * Offsets, field positions, reset values and trigger codes of the DMA channel
 * status and trigger-select logic. Assumes inclusion by the package and modules.
 */
`ifndef DMA_CHAN_PARAMS_SVH
`define DMA_CHAN_PARAMS_SVH

`define REG_ADDR_W 4
`define CHAN_INT_STATUS_OFS 4'h0

`define ST_BUF_PEND_BIT 15
`define ST_CODE_MSB 14
`define ST_CODE_LSB 8
`define ST_UPPER_BIT 7
`define ST_LOWER_BIT 6
`define ST_DONE_BIT 5
`define ST_HALF_BIT 4
`define ST_OVR_BIT 3
`define ST_HALF_EN_BIT 0

`define CODE_RESET 7'h00
`define FLAGS_RESET 5'h00
`define RDATA_RESET 16'h0000

`define TRIG_EXT_IRQ0 7'h00
`define TRIG_EXT_IRQ1 7'h08
`define TRIG_EXT_IRQ2 7'h0b
`define TRIG_EXT_IRQ3 7'h0d
`define TRIG_MEM_ECC 7'h06
`define TRIG_TWO_WIRE_ONE 7'h09
`define TRIG_TWO_WIRE_TWO 7'h13
`define TRIG_TWO_WIRE_THREE 7'h64
`define TRIG_CHECKSUM 7'h18
`define TRIG_CONV_GROUP 7'h27
`define TRIG_CONV_FIRST 7'h28
`define TRIG_CONV_LAST 7'h3f
`define TRIG_FILTER_FIRST 7'h40
`define TRIG_FILTER_LAST 7'h43
`define TRIG_CELL_ONE 7'h44
`define TRIG_CELL_TWO 7'h45
`define TRIG_CELL_THREE 7'h60
`define TRIG_CELL_FOUR 7'h61
`define TRIG_RSV_A 7'h1a
`define TRIG_RSV_B_FIRST 7'h48
`define TRIG_RSV_B_LAST 7'h56
`define TRIG_RSV_C 7'h5a
`define TRIG_RSV_D 7'h5b
`define TRIG_RSV_E 7'h5e
`define TRIG_RSV_F 7'h5f
`define TRIG_RSV_G_FIRST 7'h6e

`endif

// *** rtl/dma_chan_pkg.sv ***
/*
 * Types shared by the DMA channel status logic and its trigger selector.
 * Assumes the params header is on the include path.
 */
`include "dma_chan_params.svh"

package dma_chan_pkg;

    typedef logic [6:0] trig_code_t;

    typedef struct packed {
        logic upper;
        logic lower;
        logic done;
        logic half;
        logic ovr;
    } flags_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } access_t;

endpackage : dma_chan_pkg

// *** rtl/trigger_select.sv ***
/*
 * Picks one peripheral interrupt line by trigger-select code and turns its
 * rising edge into a single-cycle trigger. Sources are on the system clock.
 */
`timescale 1ns/1ps
`include "dma_chan_params.svh"

module trigger_select
    import dma_chan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire trig_code_t code,
    input wire logic [127:0] src_irq,
    output logic trig_evt
);

    logic [127:0] prev_reg;
    logic [127:0] prev_next;
    logic code_ok;

    // Reserved codes are never armed, so a stray source on them is harmless.
    always_comb begin
        code_ok = 1'b1;
        if (code == `TRIG_RSV_A || code == `TRIG_RSV_C || code == `TRIG_RSV_D ||
            code == `TRIG_RSV_E || code == `TRIG_RSV_F) begin
            code_ok = 1'b0;
        end
        if ((code >= `TRIG_RSV_B_FIRST && code <= `TRIG_RSV_B_LAST) ||
            code >= `TRIG_RSV_G_FIRST) begin
            code_ok = 1'b0;
        end
    end

    // Every line is sampled each enabled cycle, so a code change does not fake an edge.
    always_comb begin
        prev_next = prev_reg;
        if (clk_en) begin
            prev_next = src_irq;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // Line n of src_irq is the source for code n; only the selected one counts.
    assign trig_evt = clk_en && code_ok && src_irq[code] && !prev_reg[code];

endmodule : trigger_select

// *** sim/engine_model.sv ***
/*
 * Transfer engine model for the channel status block.
 * Assumes one clock; a trigger loads the count, then it counts down.
 */
`timescale 1ns/1ps

module engine_model
    import dma_chan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic trigger_pulse,
    input wire logic [15:0] count_init,
    input wire logic [15:0] addr,
    output logic busy,
    output logic cnt_dec,
    output logic xfer_done,
    output logic [15:0] cnt,
    output access_t access
);
    logic ph;

    // The slow mode steps on every other cycle, to stretch the busy window.
    always @(posedge clk) begin
        cnt_dec <= 1'b0;
        xfer_done <= 1'b0;
        access <= '0;
        ph <= ~ph;
        if (!rst_b) begin
            busy <= 1'b0;
            cnt <= 16'h0000;
            ph <= 1'b0;
        end else if (trigger_pulse && !busy) begin
            busy <= 1'b1;
            cnt <= count_init;
        end else if (busy && cnt != 16'h0000 && (!slow || ph)) begin
            cnt <= cnt - 16'h0001;
            cnt_dec <= 1'b1;
            access <= '{valid: 1'b1, addr: addr};
        end else if (busy && cnt == 16'h0000) begin
            busy <= 1'b0;
            xfer_done <= 1'b1;
        end
    end
endmodule : engine_model

// *** sim/testbench.sv ***
/*
 * Self-checking bench of the channel status block.
 * Assumes the engine model on the far side and a 25 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end

module testbench;
    import dma_chan_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic en = 1'b0, slow = 1'b0, bwp = 1'b0, ce = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, cinit = 16'h0002, addr = 16'h2000;
    logic [15:0] reg_rdata, cnt, d;
    logic [127:0] src_irq = '0;
    logic busy, xfer_done, cnt_dec, trigger_pulse, channel_irq;
    access_t access;
    int bad_count = 0, checks = 0, irq_n = 0, trig_n = 0, cyc = 0, n0;
    logic [6:0] codes [18] = '{7'h00, 7'h08, 7'h0b, 7'h0d, 7'h27, 7'h28, 7'h3f,
        7'h40, 7'h43, 7'h44, 7'h45, 7'h60, 7'h61, 7'h18, 7'h06, 7'h09, 7'h13, 7'h64};
    logic [6:0] rsv [9] = '{7'h1a, 7'h48, 7'h56, 7'h5a, 7'h5b, 7'h5e, 7'h5f,
        7'h6e, 7'h7f};

    always #20 clk = ~clk;

    dma_channel_status i_dma_channel_status (.clk(clk), .rst_b(rst_b),
        .clk_en(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_irq(src_irq), .channel_enable(en), .busy(busy),
        .xfer_done(xfer_done), .cnt_dec(cnt_dec), .channel_transfer_counter(cnt),
        .count_init(cinit), .access(access), .upper_address_limit(16'h8000),
        .lower_address_limit(16'h1000), .buf_write_pending(bwp),
        .trigger_pulse(trigger_pulse), .channel_irq(channel_irq));

    engine_model i_engine_model (.clk(clk), .rst_b(rst_b), .slow(slow),
        .trigger_pulse(trigger_pulse), .count_init(cinit), .addr(addr),
        .busy(busy), .cnt_dec(cnt_dec), .xfer_done(xfer_done), .cnt(cnt),
        .access(access));

    task summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cyc++;
        if (channel_irq === 1'b1) irq_n++;
        if (trigger_pulse === 1'b1) trig_n++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd

    task pulse(input int b);
        @(posedge clk);
        src_irq[b] <= 1'b1;
        @(posedge clk);
        src_irq[b] <= 1'b0;
    endtask : pulse

    // Waits for the engine to go idle, bounded so a hang cannot stall here.
    task settle;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : settle

    task lim(input logic [15:0] a, input logic [15:0] e);
        wr(4'h0, 16'h0000);
        addr <= a;
        pulse(0);
        settle();
        rd(4'h0);
        `CHK("limit flags", e, d & 16'h00c0)
    endtask : lim

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0);
        `CHK("reset status", 16'h0000, d)
        n0 = irq_n;
        bwp <= 1'b1;
        wr(4'h0, 16'hbfff);
        rd(4'h0);
        `CHK("all ones", 16'hbff9, d)
        `CHK("sw set irq", n0, irq_n)
        bwp <= 1'b0;
        wr(4'h0, 16'h0000);
        rd(4'h0);
        `CHK("cleared", 16'h0000, d)
        rd(4'h5);
        `CHK("unmapped", 16'h0000, d)
        $display("test registers done");
        en <= 1'b1;
        foreach (codes[i]) begin
            wr(4'h0, {1'b0, codes[i], 8'h00});
            n0 = trig_n;
            pulse(codes[i] ^ 7'h01);
            pulse(codes[i]);
            settle();
            `CHK("trigger", n0 + 1, trig_n)
        end
        foreach (rsv[i]) begin
            wr(4'h0, {1'b0, rsv[i], 8'h00});
            n0 = trig_n;
            pulse(rsv[i]);
            settle();
            `CHK("reserved", n0, trig_n)
        end
        $display("test trigger map done");
        wr(4'h0, 16'h0000);
        en <= 1'b0;
        cinit <= 16'h0008;
        @(posedge clk);
        en <= 1'b1;
        wr(4'h0, 16'h0001);
        n0 = irq_n;
        pulse(0);
        settle();
        rd(4'h0);
        `CHK("half and done", 16'h0031, d)
        `CHK("irq count on", n0 + 2, irq_n)
        en <= 1'b0;
        rd(4'h0);
        `CHK("done disabled", 16'h0031, d)
        en <= 1'b1;
        rd(4'h0);
        `CHK("done new session", 16'h0011, d)
        wr(4'h0, 16'h0000);
        slow <= 1'b1;
        n0 = irq_n;
        pulse(0);
        settle();
        rd(4'h0);
        `CHK("half no enable", 16'h0030, d)
        `CHK("irq count off", n0 + 1, irq_n)
        slow <= 1'b0;
        $display("test halfway done");
        wr(4'h0, 16'h0000);
        pulse(0);
        pulse(0);
        settle();
        rd(4'h0);
        `CHK("overrun", 16'h0038, d)
        lim(16'h9000, 16'h0080);
        lim(16'h0800, 16'h0040);
        $display("test overrun and limits done");
        wr(4'h0, 16'h0000);
        n0 = trig_n;
        ce <= 1'b0;
        wr(4'h0, 16'h0020);
        pulse(0);
        ce <= 1'b1;
        rd(4'h0);
        `CHK("frozen status", 16'h0000, d)
        `CHK("frozen trigger", n0, trig_n)
        $display("test clock enable done");
        summarize();
    end
endmodule : testbench
